/* logic/dphy_timing_defines.vh */
// Register map, field layout and timing constants for the lane timing override block
`ifndef DPHY_TIMING_DEFINES_VH
`define DPHY_TIMING_DEFINES_VH
`define IDX_CLK_PREP        8'h40
`define IDX_CLK_ZERO        8'h41
`define IDX_CLK_TRAIL       8'h42
`define IDX_CLK_POST        8'h43
`define IDX_DAT_PREP        8'h44
`define IDX_CTRL            8'h50
`define IDX_STATUS          8'h51
`define IDX_RATE            8'h52
`define REG_COUNT           5
`define OVR_BIT             7
`define VAL_MSB             6
`define VAL_W               7
`define VAL_RESET           7'h00
`define OVR_RESET           1'b0
`define RATE_RESET          8'h10
`define AUTO_PREP_NUM       8'h04
`define AUTO_ZERO_NUM       8'h20
`define AUTO_TRAIL_NUM      8'h06
`define AUTO_POST_NUM       8'h0A
`define AUTO_DPREP_NUM      8'h05
`define HTRANS_NONSEQ       2'b10
`define ADDR_IDX_MSB        9
`define ADDR_IDX_LSB        2
`define CTRL_HS_BIT         0
`define RATE_MSB            7
`define AUTO_SHIFT          4
`define AUTO_MAX            7'h7F
`endif

/* logic/dphy_timing_override.v */
// Lane timing override registers on AHB-Lite with a clock/data lane high-speed sequencer
`include "dphy_timing_defines.vh"
module dphy_timing_override (
    input  wire        clk,
    input  wire        rst,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire        link_clk,
    output reg         clk_lane_hs,
    output reg         data_lane_hs,
    output reg         seq_busy
);
    localparam ST_IDLE  = 3'd0;
    localparam ST_CPREP = 3'd1;
    localparam ST_CZERO = 3'd2;
    localparam ST_DPREP = 3'd3;
    localparam ST_DATA  = 3'd4;
    localparam ST_POST  = 3'd5;
    localparam ST_TRAIL = 3'd6;

    // Register storage, one entry per timing register
    reg                ovr_q   [0:`REG_COUNT-1];
    reg [`VAL_W-1:0]   sw_q    [0:`REG_COUNT-1];
    wire [`VAL_W-1:0]  auto_v  [0:`REG_COUNT-1];
    wire [`VAL_W-1:0]  eff_v   [0:`REG_COUNT-1];
    reg                hs_req_q;
    reg [7:0]          rate_q;
    reg                wr_pend_q;
    reg [7:0]          wr_idx_q;
    reg [2:0]          state_q;
    reg [2:0]          state_d;
    reg                cnt_load;
    reg [`VAL_W-1:0]   cnt_value;
    wire               link_tick;
    wire               cnt_done;
    wire [7:0]         acc_idx;
    wire               acc_valid;
    wire [7:0]         wr_sel;
    wire               ctrl_wr;
    wire               rate_wr;
    wire               clk_lane_hs_d;
    wire               data_lane_hs_d;
    wire               seq_busy_d;
    reg [31:0]         read_word_d;

    // Named fields of the five timing registers
    wire               clk_prepare_override_flag;
    wire [`VAL_W-1:0]  clk_prepare_interval_value;
    wire               clk_zero_override_flag;
    wire [`VAL_W-1:0]  clk_zero_interval_value;
    wire               clk_trail_override_flag;
    wire [`VAL_W-1:0]  clk_trail_interval_value;
    wire               clk_post_override_flag;
    wire [`VAL_W-1:0]  clk_post_interval_value;
    wire               data_prepare_override_flag;
    wire [`VAL_W-1:0]  data_prepare_interval_value;

    // Automatic values scale with the programmed byte clock rate
    function [`VAL_W-1:0] auto_calc;
        input [7:0] num;
        input [7:0] rate;
        reg   [15:0] prod;
        reg   [15:0] scaled;
        begin
            prod      = num * rate;
            scaled    = prod >> `AUTO_SHIFT;
            auto_calc = (scaled > {9'h000, `AUTO_MAX}) ? `AUTO_MAX : scaled[`VAL_W-1:0];
        end
    endfunction

    assign auto_v[0] = auto_calc(`AUTO_PREP_NUM, rate_q);
    assign auto_v[1] = auto_calc(`AUTO_ZERO_NUM, rate_q);
    assign auto_v[2] = auto_calc(`AUTO_TRAIL_NUM, rate_q);
    assign auto_v[3] = auto_calc(`AUTO_POST_NUM, rate_q);
    assign auto_v[4] = auto_calc(`AUTO_DPREP_NUM, rate_q);

    // Effective value per register: override picks software value
    genvar g;
    generate
        for (g = 0; g < `REG_COUNT; g = g + 1) begin : g_eff
            assign eff_v[g] = ovr_q[g] ? sw_q[g] : auto_v[g];
        end
    endgenerate

    // Field names used by the read mux and the sequencer
    assign clk_prepare_override_flag   = ovr_q[0];
    assign clk_zero_override_flag      = ovr_q[1];
    assign clk_trail_override_flag     = ovr_q[2];
    assign clk_post_override_flag      = ovr_q[3];
    assign data_prepare_override_flag  = ovr_q[4];

    assign clk_prepare_interval_value  = eff_v[0];
    assign clk_zero_interval_value     = eff_v[1];
    assign clk_trail_interval_value    = eff_v[2];
    assign clk_post_interval_value     = eff_v[3];
    assign data_prepare_interval_value = eff_v[4];

    // AHB-Lite slave: zero wait state, always OKAY
    assign acc_idx   = haddr[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
    assign acc_valid = hsel & hready & htrans[1];
    assign wr_sel    = wr_idx_q - `IDX_CLK_PREP;
    assign ctrl_wr   = wr_pend_q && (wr_idx_q == `IDX_CTRL);
    assign rate_wr   = wr_pend_q && (wr_idx_q == `IDX_RATE);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h00000000;
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 8'h00;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_q <= acc_valid & hwrite;
            if (acc_valid) begin
                wr_idx_q <= acc_idx;
            end
            if (acc_valid && !hwrite) begin
                hrdata <= read_word_d;
            end
        end
    end

    // Read word for the index in the address phase; value field shows the value in force
    always @* begin
        read_word_d = 32'h00000000;
        case (acc_idx)
            `IDX_CLK_PREP: begin
                read_word_d = {24'h000000, clk_prepare_override_flag, clk_prepare_interval_value};
            end
            `IDX_CLK_ZERO: begin
                read_word_d = {24'h000000, clk_zero_override_flag, clk_zero_interval_value};
            end
            `IDX_CLK_TRAIL: begin
                read_word_d = {24'h000000, clk_trail_override_flag, clk_trail_interval_value};
            end
            `IDX_CLK_POST: begin
                read_word_d = {24'h000000, clk_post_override_flag, clk_post_interval_value};
            end
            `IDX_DAT_PREP: begin
                read_word_d = {24'h000000, data_prepare_override_flag, data_prepare_interval_value};
            end
            `IDX_CTRL: begin
                read_word_d = {31'h00000000, hs_req_q};
            end
            `IDX_STATUS: begin
                read_word_d = {26'h0000000, data_lane_hs, clk_lane_hs, seq_busy, state_q};
            end
            `IDX_RATE: begin
                read_word_d = {24'h000000, rate_q};
            end
            default: begin
                read_word_d = 32'h00000000;
            end
        endcase
    end

    // Register writes in the data phase
    generate
        for (g = 0; g < `REG_COUNT; g = g + 1) begin : g_reg
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    ovr_q[g] <= `OVR_RESET;
                    sw_q[g]  <= `VAL_RESET;
                end else if (wr_pend_q && wr_sel == g) begin
                    ovr_q[g] <= hwdata[`OVR_BIT];
                    // Value field only takes writes whose override bit is set
                    if (hwdata[`OVR_BIT]) begin
                        sw_q[g] <= hwdata[`VAL_MSB:0];
                    end else begin
                        sw_q[g] <= sw_q[g];
                    end
                end
            end
        end
    endgenerate

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            hs_req_q <= 1'b0;
            rate_q   <= `RATE_RESET;
        end else begin
            if (ctrl_wr) begin
                hs_req_q <= hwdata[`CTRL_HS_BIT];
            end
            if (rate_wr) begin
                rate_q <= hwdata[`RATE_MSB:0];
            end
        end
    end

    // Lane sequencer timed in byte clock ticks
    link_edge_detect u_edge (
        .clk       (clk),
        .rst       (rst),
        .link_clk  (link_clk),
        .link_rise (link_tick)
    );

    interval_counter #(
        .W (`VAL_W)
    ) u_cnt (
        .clk   (clk),
        .rst   (rst),
        .load  (cnt_load),
        .value (cnt_value),
        .tick  (link_tick),
        .done  (cnt_done)
    );

    always @* begin
        state_d   = state_q;
        cnt_load  = 1'b0;
        cnt_value = {`VAL_W{1'b0}};
        case (state_q)
            ST_IDLE: begin
                if (hs_req_q) begin
                    state_d   = ST_CPREP;
                    cnt_load  = 1'b1;
                    cnt_value = clk_prepare_interval_value;
                end
            end
            ST_CPREP: begin
                if (cnt_done) begin
                    state_d   = ST_CZERO;
                    cnt_load  = 1'b1;
                    cnt_value = clk_zero_interval_value;
                end
            end
            ST_CZERO: begin
                if (cnt_done) begin
                    state_d   = ST_DPREP;
                    cnt_load  = 1'b1;
                    cnt_value = data_prepare_interval_value;
                end
            end
            ST_DPREP: begin
                if (cnt_done) begin
                    state_d = ST_DATA;
                end
            end
            ST_DATA: begin
                if (!hs_req_q) begin
                    state_d   = ST_POST;
                    cnt_load  = 1'b1;
                    cnt_value = clk_post_interval_value;
                end
            end
            ST_POST: begin
                if (cnt_done) begin
                    state_d   = ST_TRAIL;
                    cnt_load  = 1'b1;
                    cnt_value = clk_trail_interval_value;
                end
            end
            ST_TRAIL: begin
                if (cnt_done) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Lane levels follow the next state so the outputs come straight from flops
    assign clk_lane_hs_d  = (state_d == ST_CZERO) || (state_d == ST_DPREP) || (state_d == ST_DATA)
                            || (state_d == ST_POST) || (state_d == ST_TRAIL);
    assign data_lane_hs_d = (state_d == ST_DATA);
    assign seq_busy_d     = (state_d != ST_IDLE) && (state_d != ST_DATA);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q      <= ST_IDLE;
            clk_lane_hs  <= 1'b0;
            data_lane_hs <= 1'b0;
            seq_busy     <= 1'b0;
        end else begin
            state_q      <= state_d;
            clk_lane_hs  <= clk_lane_hs_d;
            data_lane_hs <= data_lane_hs_d;
            seq_busy     <= seq_busy_d;
        end
    end
endmodule

/* logic/interval_counter.v */
// Loadable down counter that times one lane interval in byte clock ticks
module interval_counter #(
    parameter W = 7
) (
    input  wire         clk,
    input  wire         rst,
    input  wire         load,
    input  wire [W-1:0] value,
    input  wire         tick,
    output wire         done
);
    reg [W-1:0] count_q;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q <= {W{1'b0}};
        end else if (load) begin
            count_q <= value;
        end else if (tick && count_q != {W{1'b0}}) begin
            count_q <= count_q - {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign done = (count_q == {W{1'b0}});
endmodule

/* logic/link_edge_detect.v */
// Two-flop synchroniser for the lane byte clock plus rising edge detector
module link_edge_detect (
    input  wire clk,
    input  wire rst,
    input  wire link_clk,
    output reg  link_rise
);
    reg sync1_q;
    reg sync2_q;
    reg sync3_q;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_q   <= 1'b0;
            sync2_q   <= 1'b0;
            sync3_q   <= 1'b0;
            link_rise <= 1'b0;
        end else begin
            sync1_q   <= link_clk;
            sync2_q   <= sync1_q;
            sync3_q   <= sync2_q;
            link_rise <= sync2_q & ~sync3_q;
        end
    end
endmodule

/* sim/csi_receiver_model.sv */
// Receiver model: makes the lane byte clock and counts ticks before clock lane entry
module csi_receiver_model (
    input  wire  clk_lane_hs,
    input  wire  run,
    output logic link_clk,
    output int   ticks
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        link_clk = 1'b0;
        ticks = 0;
        #7;
        forever begin
            #160;
            link_clk = run ? ~link_clk : 1'b0;
            if (run && link_clk && !clk_lane_hs) ticks++;
            if (!run) ticks = 0;
        end
    end
endmodule

/* sim/dphy_timing_override_assertions.sv */
// Port checker for the lane timing override block
module dphy_timing_override_checker (
    input wire        clk,
    input wire        rst,
    input wire        hsel,
    input wire [1:0]  htrans,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    input wire        clk_lane_hs,
    input wire        data_lane_hs,
    input wire        seq_busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_ready_high: assert property (hreadyout) else $error("hreadyout low");
    chk_resp_okay: assert property (!hresp) else $error("hresp not okay");
    chk_upper_zero: assert property (hrdata[31:8] == 24'h000000) else $error("upper read bits set");
    chk_read_holds: assert property (!(hsel && hready && htrans[1]) |=> $stable(hrdata))
        else $error("read data moved");
    chk_prep_busy: assert property ($rose(clk_lane_hs) |-> $past(seq_busy))
        else $error("clock lane entered without prepare");
    chk_data_in_clk: assert property (data_lane_hs |-> clk_lane_hs) else $error("data without clock lane");
    chk_zero_first: assert property ($rose(data_lane_hs) |-> $past(clk_lane_hs) && $past(seq_busy))
        else $error("data lane entered early");
    chk_trail_last: assert property ($fell(clk_lane_hs) |-> !data_lane_hs && $past(seq_busy))
        else $error("clock lane left early");
endmodule

bind dphy_timing_override dphy_timing_override_checker chk (
    .clk(clk), .rst(rst), .hsel(hsel), .htrans(htrans), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .clk_lane_hs(clk_lane_hs), .data_lane_hs(data_lane_hs),
    .seq_busy(seq_busy));

/* sim/dphy_timing_override_tb_top.sv */
// Testbench for the lane timing override block
`include "dphy_timing_defines.vh"
module dphy_timing_override_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, hsel, hwrite, run;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, rd;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, clk_lane_hs, data_lane_hs, seq_busy, link_clk;
    int          bad_count, n_compared, ticks, i;
    logic [7:0]  idx [5] = '{`IDX_CLK_PREP, `IDX_CLK_ZERO, `IDX_CLK_TRAIL, `IDX_CLK_POST, `IDX_DAT_PREP};
    logic [7:0]  num [5] = '{`AUTO_PREP_NUM, `AUTO_ZERO_NUM, `AUTO_TRAIL_NUM, `AUTO_POST_NUM, `AUTO_DPREP_NUM};

    dphy_timing_override dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .link_clk(link_clk), .clk_lane_hs(clk_lane_hs),
        .data_lane_hs(data_lane_hs), .seq_busy(seq_busy));
    csi_receiver_model rx (.clk_lane_hs(clk_lane_hs), .run(run), .link_clk(link_clk), .ticks(ticks));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic [31:0] auto_v(input logic [7:0] n, input logic [7:0] r);
        logic [15:0] p;
        p = (n * r) >> 4;
        return (p > 16'h007F) ? 32'h0000007F : {16'h0000, p};
    endfunction

    task automatic bus(input logic wr, input logic [7:0] ix, input logic [31:0] wd);
        htrans <= `HTRANS_NONSEQ;
        hwrite <= wr;
        haddr <= {22'h000000, ix, 2'h0};
        do begin @(posedge clk); end while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do begin @(posedge clk); end while (hreadyout !== 1'b1);
        rd = hrdata;
        cmp("response", 32'h00000000, {31'h0, hresp});
    endtask

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rdc(input string what, input logic [7:0] ix, input logic [31:0] exp);
        bus(1'b0, ix, 32'h00000000);
        cmp(what, exp, rd);
    endtask

    task automatic wait_lane(input logic want);
        int n;
        n = 0;
        while (clk_lane_hs !== want && n < 3000) begin @(posedge clk); n++; end
        if (n >= 3000) bad_count++;
        repeat (200) @(posedge clk);
    endtask

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        #400000;
        bad_count++;
        tally_and_finish();
    end

    initial begin
        rst = 1'b1;
        hsel = 1'b1;
        hwrite = 1'b0;
        htrans = 2'h0;
        haddr = 32'h00000000;
        hwdata = 32'h00000000;
        run = 1'b0;
        bad_count = 0;
        n_compared = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (i = 0; i < 5; i++) begin
            rdc("auto", idx[i], auto_v(num[i], `RATE_RESET));
            bus(1'b1, idx[i], 32'h00000033);
            rdc("locked", idx[i], auto_v(num[i], `RATE_RESET));
        end
        bus(1'b1, `IDX_RATE, 32'h00000080);
        for (i = 0; i < 5; i++) rdc("scaled", idx[i], auto_v(num[i], 8'h80));
        rdc("rate", `IDX_RATE, 32'h00000080);
        for (i = 0; i < 5; i++) begin
            bus(1'b1, idx[i], 32'h00000082 + i);
            rdc("override", idx[i], 32'h00000082 + i);
        end
        rdc("unmapped", 8'h7F, 32'h00000000);
        $display("register tests done");
        run <= 1'b1;
        bus(1'b1, `IDX_CTRL, 32'h00000001);
        wait_lane(1'b1);
        cmp("prepare ticks", 32'h00000001, {31'h0, ticks >= 2 && ticks <= 4});
        cmp("clock lane", 32'h00000001, {31'h0, clk_lane_hs});
        cmp("data lane", 32'h00000001, {31'h0, data_lane_hs});
        rdc("control", `IDX_CTRL, 32'h00000001);
        bus(1'b0, `IDX_STATUS, 32'h00000000);
        cmp("status", 32'h00000030, rd & 32'hFFFFFFF8);
        bus(1'b1, `IDX_CTRL, 32'h00000000);
        wait_lane(1'b0);
        cmp("lanes idle", 32'h00000000, {29'h0, clk_lane_hs, data_lane_hs, seq_busy});
        run <= 1'b0;
        $display("sequencer test done");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdc("after reset", `IDX_CLK_PREP, auto_v(`AUTO_PREP_NUM, `RATE_RESET));
        rdc("rate after reset", `IDX_RATE, {24'h000000, `RATE_RESET});
        $display("reset test done");
        tally_and_finish();
    end
endmodule
